// File: hdl/cbx_exec.v
// Execution of set-bits, bit-test, branch, call, clear and flag-clear ops
//
// Summary of operation
// - Set-bits writes source OR destination
// - Word set-bits to register clears bits 19:16
// - Bit test only updates flags, no write
// - Bit test keeps register upper bits intact
// - Bit test sets N from MSB, Z if zero
// - Bit test: C is not Z, V cleared
// - Branch loads 16-bit destination, flags untouched
// - Branch is a move into program counter
// - Call: hold target, push return, load PC
// - Call clears PC 19:16, flags untouched
// - Auto-increment call bumps pointer by two
// - Indexed call reads base plus signed offset
// - Clear destination writes zero, flags untouched
// - Clear carry resets only carry flag
// - Clear negative ANDs status with inverted 04h
// - Clear zero ANDs status with inverted 02h
// - Flag clears always run at word size
// - Mode bits never changed by these ops
`timescale 1ns/1ps
`default_nettype none
`include "cbx_consts.vh"
module cbx_exec #(
  parameter AW = 20
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Instruction request
  input wire start,
  input wire [2:0] op,
  input wire byte_op,
  input wire dst_is_reg,
  input wire [1:0] call_mode,
  input wire [AW-1:0] src_val,
  input wire [AW-1:0] dst_val,
  input wire [AW-1:0] ptr_val,
  input wire [15:0] index_off,
  input wire [AW-1:0] return_pc,
  input wire [AW-1:0] sp_in,
  output wire busy,
  output reg done_q,
  // Destination write-back
  output reg dst_we_q,
  output reg [AW-1:0] dst_wdata_q,
  output reg dst_byte_q,
  // Pointer register write-back
  output reg ptr_we_q,
  output reg [AW-1:0] ptr_wdata_q,
  // Stack pointer write-back
  output reg sp_we_q,
  output reg [AW-1:0] sp_wdata_q,
  // Memory access
  output reg mem_rd_q,
  output reg mem_wr_q,
  output reg [AW-1:0] mem_addr_q,
  output reg [15:0] mem_wdata_q,
  input wire [15:0] mem_rdata,
  input wire mem_ack,
  // Program counter and status register
  output reg pc_we_q,
  output reg [AW-1:0] pc_q,
  output reg [15:0] status_register_q
);
  // ==========================================================
  // States
  // ==========================================================
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_FETCH = 3'd1;
  localparam [2:0] ST_PUSH = 3'd2;
  localparam [2:0] ST_STORE = 3'd3;
  localparam [2:0] ST_LOAD = 3'd4;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [15:0] target_q;
  reg [AW-1:0] ret_q;
  reg [AW-1:0] sp_new_q;

  wire [AW-1:0] or_res;
  wire [AW-1:0] and_res;
  wire neg;
  wire zero;

  // ==========================================================
  // Logic unit
  // ==========================================================
  cbx_logic_unit #(
    .W(AW)
  ) u_lu (
    .src(src_val),
    .dst(dst_val),
    .byte_op(byte_op),
    .or_res(or_res),
    .and_res(and_res),
    .neg(neg),
    .zero(zero)
  );

  assign busy = (state_q != ST_IDLE);

  // Sign-extended index offset for indexed call
  function [AW-1:0] sext16;
    input [15:0] v;
    begin
      sext16 = {{(AW-16){v[15]}}, v};
    end
  endfunction

  // ==========================================================
  // Sequencer
  // ==========================================================
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start && op == `CBX_OP_CALL) begin
          if (call_mode == `CBX_MODE_DIRECT)
            state_d = ST_PUSH;
          else
            state_d = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (mem_ack)
          state_d = ST_PUSH;
      end
      ST_PUSH: state_d = ST_STORE;
      ST_STORE: begin
        if (mem_ack)
          state_d = ST_LOAD;
      end
      ST_LOAD: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      target_q <= 16'h0000;
      ret_q <= `CBX_PC_RESET;
      sp_new_q <= `CBX_PC_RESET;
      done_q <= 1'b0;
      dst_we_q <= 1'b0;
      dst_wdata_q <= `CBX_PC_RESET;
      dst_byte_q <= 1'b0;
      ptr_we_q <= 1'b0;
      ptr_wdata_q <= `CBX_PC_RESET;
      sp_we_q <= 1'b0;
      sp_wdata_q <= `CBX_PC_RESET;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_addr_q <= `CBX_PC_RESET;
      mem_wdata_q <= 16'h0000;
      pc_we_q <= 1'b0;
      pc_q <= `CBX_PC_RESET;
      status_register_q <= `CBX_SR_RESET;
    end else begin
      state_q <= state_d;
      done_q <= 1'b0;
      dst_we_q <= 1'b0;
      ptr_we_q <= 1'b0;
      sp_we_q <= 1'b0;
      pc_we_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            dst_byte_q <= byte_op;
            case (op)
              `CBX_OP_SET_BITS: begin
                // Register word result drops 19:16; memory keeps operand size
                dst_we_q <= 1'b1;
                dst_wdata_q <= or_res;
                done_q <= 1'b1;
              end
              `CBX_OP_BIT_TEST: begin
                // No write-back: register upper bits stay as they were
                status_register_q[`CBX_SR_N] <= neg;
                status_register_q[`CBX_SR_Z] <= zero;
                status_register_q[`CBX_SR_C] <= ~zero;
                status_register_q[`CBX_SR_V] <= 1'b0;
                done_q <= 1'b1;
              end
              `CBX_OP_BRANCH: begin
                // Move of destination into PC, any source mode
                pc_we_q <= 1'b1;
                pc_q <= {{(AW-16){1'b0}}, dst_val[15:0]};
                done_q <= 1'b1;
              end
              `CBX_OP_CALL: begin
                ret_q <= return_pc;
                sp_new_q <= sp_in - `CBX_STACK_STEP;
                if (call_mode == `CBX_MODE_DIRECT) begin
                  target_q <= dst_val[15:0];
                end else begin
                  mem_rd_q <= 1'b1;
                  if (call_mode == `CBX_MODE_INDEXED)
                    mem_addr_q <= ptr_val + sext16(index_off);
                  else
                    mem_addr_q <= ptr_val;
                end
              end
              `CBX_OP_CLEAR_DEST: begin
                dst_we_q <= 1'b1;
                dst_wdata_q <= {AW{1'b0}};
                done_q <= 1'b1;
              end
              `CBX_OP_CLEAR_CARRY: begin
                // Word-size clear-bits on status; mode bits kept
                status_register_q <= status_register_q & ~`CBX_MASK_CARRY;
                done_q <= 1'b1;
              end
              `CBX_OP_CLEAR_NEG: begin
                status_register_q <= status_register_q & ~`CBX_MASK_NEG;
                done_q <= 1'b1;
              end
              default: begin
                status_register_q <= status_register_q & ~`CBX_MASK_ZERO;
                done_q <= 1'b1;
              end
            endcase
          end
        end
        ST_FETCH: begin
          if (mem_ack) begin
            mem_rd_q <= 1'b0;
            target_q <= mem_rdata;
            if (call_mode == `CBX_MODE_AUTOINC) begin
              // Pointer moves only after its word was read
              ptr_we_q <= 1'b1;
              ptr_wdata_q <= ptr_val + `CBX_PTR_STEP;
            end
          end
        end
        ST_PUSH: begin
          sp_we_q <= 1'b1;
          sp_wdata_q <= sp_new_q;
          mem_wr_q <= 1'b1;
          mem_addr_q <= sp_new_q;
          mem_wdata_q <= ret_q[15:0];
        end
        ST_STORE: begin
          if (mem_ack)
            mem_wr_q <= 1'b0;
        end
        ST_LOAD: begin
          // Status flags untouched by the call
          pc_we_q <= 1'b1;
          pc_q <= {{(AW-16){1'b0}}, target_q};
          done_q <= 1'b1;
        end
        default: begin
          mem_rd_q <= 1'b0;
          mem_wr_q <= 1'b0;
        end
      endcase
    end
  end
endmodule // cbx_exec
`default_nettype wire

// File: hdl/cbx_consts.vh
// Constants for the bit-op, branch and call execution block
`ifndef CBX_CONSTS_VH
`define CBX_CONSTS_VH
// Status register field positions
`define CBX_SR_C 0
`define CBX_SR_Z 1
`define CBX_SR_N 2
`define CBX_SR_GIE 3
`define CBX_SR_CORE_HALT_BIT 4
`define CBX_SR_OSCILLATOR_OFF_BIT 5
`define CBX_SR_V 8
// Flag clear masks (inverted constants)
`define CBX_MASK_CARRY 16'h0001
`define CBX_MASK_ZERO 16'h0002
`define CBX_MASK_NEG 16'h0004
// Operation codes
`define CBX_OP_SET_BITS 3'h0
`define CBX_OP_BIT_TEST 3'h1
`define CBX_OP_BRANCH 3'h2
`define CBX_OP_CALL 3'h3
`define CBX_OP_CLEAR_DEST 3'h4
`define CBX_OP_CLEAR_CARRY 3'h5
`define CBX_OP_CLEAR_NEG 3'h6
`define CBX_OP_CLEAR_ZERO 3'h7
// Call target modes
`define CBX_MODE_DIRECT 2'h0
`define CBX_MODE_INDIRECT 2'h1
`define CBX_MODE_AUTOINC 2'h2
`define CBX_MODE_INDEXED 2'h3
// Stack step and pointer step, in bytes
`define CBX_STACK_STEP 20'h0_0002
`define CBX_PTR_STEP 20'h0_0002
// Reset values
`define CBX_SR_RESET 16'h0000
`define CBX_PC_RESET 20'h0_0000
`endif

// File: hdl/cbx_logic_unit.v
// Combinational logic unit: OR, AND and flag evaluation
`timescale 1ns/1ps
`default_nettype none
`include "cbx_consts.vh"
module cbx_logic_unit #(
  parameter W = 20
) (
  // Operands
  input wire [W-1:0] src,
  input wire [W-1:0] dst,
  input wire byte_op,
  // Results
  output wire [W-1:0] or_res,
  output wire [W-1:0] and_res,
  output wire neg,
  output wire zero
);
  // OR result cleared above the operand size
  assign or_res = byte_op ? {{(W-8){1'b0}}, src[7:0] | dst[7:0]} :
                            {{(W-16){1'b0}}, src[15:0] | dst[15:0]};
  assign and_res = src & dst;
  assign neg = byte_op ? and_res[7] : and_res[15];
  assign zero = byte_op ? (and_res[7:0] == 8'h00) : (and_res[15:0] == 16'h0000);
endmodule // cbx_logic_unit
`default_nettype wire

// File: tb/cbx_exec_props.sv
// Checker for the bit-op, branch and call execution block
`timescale 1ns/1ps
`default_nettype none
module cbx_exec_props (
  // Clock, reset and request
  input wire sys_clk,
  input wire rst_b,
  input wire start,
  input wire busy,
  input wire [2:0] op,
  input wire byte_op,
  input wire [1:0] call_mode,
  input wire [19:0] src_val,
  input wire [19:0] dst_val,
  input wire [19:0] ptr_val,
  input wire [15:0] index_off,
  input wire [19:0] return_pc,
  input wire [19:0] sp_in,
  // Results
  input wire dst_we_q,
  input wire [19:0] dst_wdata_q,
  input wire ptr_we_q,
  input wire [19:0] ptr_wdata_q,
  input wire mem_rd_q,
  input wire mem_wr_q,
  input wire [19:0] mem_addr_q,
  input wire [15:0] mem_wdata_q,
  input wire pc_we_q,
  input wire [19:0] pc_q,
  input wire [15:0] status_register_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire go = start && !busy;
  wire [15:0] keep = op == 3'h5 ? 16'hFFFE : op == 3'h6 ? 16'hFFFB : 16'hFFFD;
  sequence push_s;
    ##[1:12] (mem_wr_q && mem_addr_q == sp_in - 20'h0_0002 && mem_wdata_q == return_pc[15:0]);
  endsequence
  sequence load_s;
    ##[1:12] (pc_we_q && pc_q[19:16] == 4'h0);
  endsequence
  chk_call_order:
    assert property (go && op == 3'h3 |-> push_s ##0 load_s) else $error("call order");
  chk_set_word:
    assert property (go && op == 3'h0 && !byte_op |=> dst_we_q
      && dst_wdata_q == (($past(src_val) | $past(dst_val)) & 20'h0_FFFF)) else $error("set");
  chk_test_flags:
    assert property (go && op == 3'h1 |=> !dst_we_q && !status_register_q[8]
      && status_register_q[0] == !status_register_q[1]) else $error("bit test");
  chk_branch_pc:
    assert property (go && op == 3'h2 |=> pc_we_q && $stable(status_register_q)
      && pc_q == ($past(dst_val) & 20'h0_FFFF)) else $error("branch");
  chk_clear_dest:
    assert property (go && op == 3'h4 |=> dst_we_q && dst_wdata_q == 20'h0_0000
      && $stable(status_register_q)) else $error("clear dest");
  chk_flag_clear:
    assert property (go && op > 3'h4 |=>
      status_register_q == ($past(status_register_q) & $past(keep))) else $error("flag clear");
  chk_mode_bits:
    assert property ($stable(status_register_q[5:3])) else $error("mode bits moved");
  chk_ptr_step:
    assert property (ptr_we_q |-> call_mode == 2'h2
      && ptr_wdata_q == ptr_val + 20'h0_0002) else $error("pointer step");
  chk_fetch_addr:
    assert property (mem_rd_q |-> mem_addr_q == ptr_val
      + (call_mode == 2'h3 ? {{4{index_off[15]}}, index_off} : 20'h0_0000)) else $error("fetch");
endmodule // cbx_exec_props
bind cbx_exec cbx_exec_props u_props (.sys_clk, .rst_b, .start, .busy, .op, .byte_op,
  .call_mode, .src_val, .dst_val, .ptr_val, .index_off, .return_pc, .sp_in, .dst_we_q,
  .dst_wdata_q, .ptr_we_q, .ptr_wdata_q, .mem_rd_q, .mem_wr_q, .mem_addr_q, .mem_wdata_q,
  .pc_we_q, .pc_q, .status_register_q);
`default_nettype wire

// File: tb/cbx_exec_tb_top.sv
// Self-checking bench for the bit-op, branch and call execution block
`timescale 1ns/1ps
`default_nettype none
module cbx_exec_tb_top;
  logic sys_clk = 0, rst_b = 0, start = 0, byte_op = 0, mem_ack = 0;
  logic [2:0] op = 0;
  logic [1:0] call_mode = 0, cyc = 0;
  logic [19:0] src_val = 0, dst_val = 0, ptr_val = 0, return_pc = 0, sp_in = 0;
  logic [15:0] index_off = 0, mem_rdata = 0, tgt = 0, sr_m = 0;
  logic [31:0] rnd = 32'h620b;
  logic busy, done_q, dst_we_q, ptr_we_q, sp_we_q, mem_rd_q, mem_wr_q, pc_we_q, dst_byte_q;
  logic [19:0] dst_wdata_q, ptr_wdata_q, sp_wdata_q, mem_addr_q, pc_q;
  logic [15:0] mem_wdata_q, status_register_q;
  logic [37:0] note;
  logic [37:0] exp_q[$];
  int errors = 0, n_tests = 0;
  cbx_exec u_cbx_exec (.sys_clk, .rst_b, .start, .op, .byte_op, .dst_is_reg(1'b1), .call_mode,
    .src_val, .dst_val, .ptr_val, .index_off, .return_pc, .sp_in, .busy, .done_q, .dst_we_q,
    .dst_wdata_q, .dst_byte_q, .ptr_we_q, .ptr_wdata_q, .sp_we_q, .sp_wdata_q, .mem_rd_q,
    .mem_wr_q, .mem_addr_q, .mem_wdata_q, .mem_rdata, .mem_ack, .pc_we_q, .pc_q,
    .status_register_q);
  initial forever #12.5 sys_clk = ~sys_clk;
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input [19:0] seen, input [19:0] want);
    n_tests++;
    if (seen !== want) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ====================
  // Driver
  task automatic run(input [2:0] o, input [1:0] m);
    logic [19:0] t, v;
    @(posedge sys_clk);
    #1;
    rnd = lfsr(rnd);
    src_val = rnd[19:0];
    dst_val = rnd[31:12];
    byte_op = rnd[5];
    ptr_val = rnd[27:8];
    index_off = rnd[31:16];
    return_pc = {4'h0, rnd[15:0]};
    sp_in = {rnd[30:12], 1'b0};
    tgt = (m == 2'h0) ? dst_val[15:0] : rnd[23:8];
    call_mode = m;
    op = o;
    t = src_val & dst_val & (byte_op ? 20'h0_00FF : 20'h0_FFFF);
    v = 20'h0_0000;
    case (o)
      3'h0: v = (src_val | dst_val) & (byte_op ? 20'h0_00FF : 20'h0_FFFF);
      3'h1: sr_m = {sr_m[15:9], 1'b0, sr_m[7:3], byte_op ? t[7] : t[15], t == 0, t != 0};
      3'h2: v = dst_val & 20'h0_FFFF;
      3'h3: v = {4'h0, tgt};
      3'h5: sr_m[0] = 1'b0;
      3'h6: sr_m[2] = 1'b0;
      3'h7: sr_m[1] = 1'b0;
      default: v = 20'h0_0000;
    endcase
    exp_q.push_back({o == 3'h2 || o == 3'h3, o == 3'h0 || o == 3'h4, sr_m, v});
    start = 1'b1;
    @(posedge sys_clk);
    #1;
    start = 1'b0;
    for (int c = 0; c < 40 && done_q !== 1'b1; c++) @(negedge sys_clk);
  endtask
  // Memory side stalls on some cycles; idle read data is inverted
  always @(posedge sys_clk) begin
    #1;
    cyc = cyc + 2'h1;
    mem_ack = (mem_rd_q | mem_wr_q) & ~mem_ack & (cyc != 2'h0);
    mem_rdata = mem_ack ? tgt : ~tgt;
  end
  // ====================
  // Monitor
  always @(negedge sys_clk) begin
    if (rst_b && done_q === 1'b1) begin
      note = exp_q.pop_front();
      check(status_register_q, note[35:20]);
      check(dst_we_q, note[36]);
      if (note[37]) check(pc_q, note[19:0]);
      if (note[36]) check(dst_wdata_q, note[19:0]);
    end
    if (rst_b && sp_we_q === 1'b1) check(sp_wdata_q, sp_in - 20'h0_0002);
    if (rst_b && ptr_we_q === 1'b1) check(ptr_wdata_q, ptr_val + 20'h0_0002);
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 64; i++) run(i[2:0], i[4:3]);
    wrap_up();
  end
  initial begin
    #(25 * 5000);
    errors++;
    wrap_up();
  end
endmodule // cbx_exec_tb_top
`default_nettype wire
